// File: dsc_map.svh
// constants for the dual sample conversion control block
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
`define DSC_CLK_MHZ        125
`define DSC_ACQ_NS         240
`define DSC_CONV_NS        400
`define DSC_AUTO_ACQ_NS    240
`define DSC_ACQ_CYC        ((`DSC_ACQ_NS * `DSC_CLK_MHZ + 999) / 1000)
`define DSC_CONV_CYC       ((`DSC_CONV_NS * `DSC_CLK_MHZ + 999) / 1000)
`define DSC_AUTO_ACQ_CYC   ((`DSC_AUTO_ACQ_NS * `DSC_CLK_MHZ + 999) / 1000)
`define DSC_CNT_W          8
`define DSC_SEL_FIRST      1'b0
`define DSC_SEL_SECOND     1'b1
`endif

// File: dsc_pkg.sv
// types for the dual sample conversion control block
package dsc_pkg;
    typedef enum logic [2:0] {
        DSC_IDLE,
        DSC_CONV_A,
        DSC_CONV_B,
        DSC_AUTO_ACQ
    } dsc_state_t;
endpackage

// File: dsc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dsc_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("dsc_sync: WIDTH must be at least 1");
    end

    always_comb begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    // reset value chosen per pin group so each reads its idle level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            q_r    <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule

// File: dsc_conv_ctrl.sv
// conversion sequencing and pair selection of a two-channel sampling converter
`timescale 1ns/1ps
`include "dsc_map.svh"
module dsc_conv_ctrl #(
    parameter int ACQ_CYC      = `DSC_ACQ_CYC,
    parameter int CONV_CYC     = `DSC_CONV_CYC,
    parameter int AUTO_ACQ_CYC = `DSC_AUTO_ACQ_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // conversion control pins
    input  wire logic conversion_start_n_i,
    input  wire logic pair_select_i,
    input  wire logic power_down_request_i,
    input  wire logic low_power_mode_i,
    // readout strobes
    input  wire logic chip_select_n_i,
    input  wire logic read_n_i,
    // status to the host
    output logic      busy_o,
    output logic      end_of_conv_a_o,
    output logic      low_power_state_o,
    output logic      data_oe_n_o,
    // analog front end steering and result valid pulses
    output logic      pair_latched_o,
    output logic      convert_a_o,
    output logic      convert_b_o,
    output logic      result_a_valid_o,
    output logic      result_b_valid_o
);
    localparam int CW = `DSC_CNT_W;

    // counts must fit the shared counter; fast-mode acquisition is host-timed
    // so ACQ_CYC only has to be sane
    if (CONV_CYC < 1 || CONV_CYC >= (1 << CW)) begin : g_bad_conv
        $error("dsc_conv_ctrl: CONV_CYC out of range");
    end
    if (AUTO_ACQ_CYC < 1 || AUTO_ACQ_CYC >= (1 << CW)) begin : g_bad_auto
        $error("dsc_conv_ctrl: AUTO_ACQ_CYC out of range");
    end
    if (ACQ_CYC < 1) begin : g_bad_acq
        $error("dsc_conv_ctrl: ACQ_CYC must be at least 1");
    end

    function automatic logic [CW-1:0] cyc_last(input int n);
        cyc_last = CW'(n - 1);
    endfunction

    // counter advance, kept at the counter width
    function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c);
        cnt_step = c + 1'b1;
    endfunction

    // last cycle of one channel conversion
    function automatic logic conv_done(input logic [CW-1:0] c);
        conv_done = (c == cyc_last(CONV_CYC));
    endfunction

    // synchronised pins
    logic start_n_s;
    logic sel_s;
    logic pd_s;
    logic lp_s;
    logic cs_n_s;
    logic rd_n_s;

    // active-low pins idle high out of reset, so no false start edge
    dsc_sync #(
        .WIDTH   (3),
        .RST_VAL (3'b111)
    ) u_sync_n (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({conversion_start_n_i, chip_select_n_i, read_n_i}),
        .q_o   ({start_n_s, cs_n_s, rd_n_s})
    );

    // level pins read low out of reset: first pair, fast mode, full power
    dsc_sync #(
        .WIDTH   (3),
        .RST_VAL (3'b000)
    ) u_sync_lvl (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({pair_select_i, power_down_request_i, low_power_mode_i}),
        .q_o   ({sel_s, pd_s, lp_s})
    );

    dsc_pkg::dsc_state_t state_r;
    dsc_pkg::dsc_state_t state_nxt;
    logic [CW-1:0]       cnt_r;
    logic [CW-1:0]       cnt_nxt;
    logic                start_n_d_r;
    logic                start_n_d_nxt;
    logic                armed_r;
    logic                armed_nxt;
    logic                pair_r;
    logic                pair_nxt;
    logic                busy_r;
    logic                busy_nxt;
    logic                eoc_a_r;
    logic                eoc_a_nxt;
    logic                lp_state_r;
    logic                lp_state_nxt;
    logic                oe_n_r;
    logic                oe_n_nxt;
    logic                va_r;
    logic                va_nxt;
    logic                vb_r;
    logic                vb_nxt;
    logic                start_edge;

    // start is a falling edge; strobes play no part here
    assign start_edge = start_n_d_r & ~start_n_s;

    // any host start edge since reset arms the self-repeat
    always_comb begin
        start_n_d_nxt = start_n_s;
        armed_nxt     = armed_r | start_edge;
    end

    // history resets to the idle pin level, so reset makes no false edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_n_d_r <= 1'b1;
            armed_r     <= 1'b0;
        end else begin
            start_n_d_r <= start_n_d_nxt;
            armed_r     <= armed_nxt;
        end
    end

    // readout enable is independent of conversion state
    always_comb begin
        oe_n_nxt = cs_n_s | rd_n_s;
    end

    // reset tristates the data bus whatever the strobes say
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= oe_n_nxt;
        end
    end

    // sequencer: idle, self-timed acquisition on a low-power self-run only, then channel A and channel B
    always_comb begin
        // pulses default low so each stands one cycle; levels hold
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        pair_nxt      = pair_r;
        busy_nxt      = busy_r;
        eoc_a_nxt     = 1'b0;
        lp_state_nxt  = lp_state_r;
        va_nxt        = 1'b0;
        vb_nxt        = 1'b0;
        case (state_r)
            dsc_pkg::DSC_IDLE: begin
                // low power outside conversion in low-power mode or on request
                lp_state_nxt = lp_s | pd_s;
                if (start_edge) begin
                    // acquisition ends at the start edge: latch pair here
                    pair_nxt     = sel_s;
                    busy_nxt     = 1'b1;
                    lp_state_nxt = 1'b0;
                    cnt_nxt      = '0;
                    state_nxt    = dsc_pkg::DSC_CONV_A;
                end else if (lp_s && armed_r && !start_n_s) begin
                    // self-run only after a first host start
                    cnt_nxt   = '0;
                    state_nxt = dsc_pkg::DSC_AUTO_ACQ;
                end
            end

            dsc_pkg::DSC_AUTO_ACQ: begin
                // device-timed acquisition, still low power
                lp_state_nxt = 1'b1;
                if (!lp_s || start_n_s) begin
                    // host let go or left the mode: wait for a fresh edge
                    state_nxt = dsc_pkg::DSC_IDLE;
                end else if (cnt_r == cyc_last(AUTO_ACQ_CYC)) begin
                    // short self-timed acquisition may beat the rated rate
                    pair_nxt     = sel_s;
                    busy_nxt     = 1'b1;
                    lp_state_nxt = 1'b0;
                    cnt_nxt      = '0;
                    state_nxt    = dsc_pkg::DSC_CONV_A;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end

            dsc_pkg::DSC_CONV_A: begin
                // neither new starts nor power-down abort this
                if (conv_done(cnt_r)) begin
                    eoc_a_nxt = 1'b1;
                    va_nxt    = 1'b1;
                    cnt_nxt   = '0;
                    state_nxt = dsc_pkg::DSC_CONV_B;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end

            // B always follows A, whatever channel the readout selects
            dsc_pkg::DSC_CONV_B: begin
                if (conv_done(cnt_r)) begin
                    vb_nxt       = 1'b1;
                    busy_nxt     = 1'b0;
                    // low power resumes on the cycle the last channel ends
                    lp_state_nxt = lp_s | pd_s;
                    cnt_nxt      = '0;
                    state_nxt    = dsc_pkg::DSC_IDLE;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end

            default: begin
                state_nxt = dsc_pkg::DSC_IDLE;
                busy_nxt  = 1'b0;
                cnt_nxt   = '0;
            end
        endcase
    end

    // reset aborts any conversion in flight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= dsc_pkg::DSC_IDLE;
            cnt_r      <= '0;
            pair_r     <= `DSC_SEL_FIRST;
            busy_r     <= 1'b0;
            eoc_a_r    <= 1'b0;
            lp_state_r <= 1'b0;
            va_r       <= 1'b0;
            vb_r       <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            pair_r     <= pair_nxt;
            busy_r     <= busy_nxt;
            eoc_a_r    <= eoc_a_nxt;
            lp_state_r <= lp_state_nxt;
            va_r       <= va_nxt;
            vb_r       <= vb_nxt;
        end
    end

    // conversion strobes registered from state for clean outputs
    logic conv_a_r;
    logic conv_b_r;
    logic conv_a_nxt;
    logic conv_b_nxt;

    always_comb begin
        conv_a_nxt = (state_nxt == dsc_pkg::DSC_CONV_A);
        conv_b_nxt = (state_nxt == dsc_pkg::DSC_CONV_B);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_a_r <= 1'b0;
            conv_b_r <= 1'b0;
        end else begin
            conv_a_r <= conv_a_nxt;
            conv_b_r <= conv_b_nxt;
        end
    end

    assign busy_o            = busy_r;
    assign end_of_conv_a_o   = eoc_a_r;
    assign low_power_state_o = lp_state_r;
    assign data_oe_n_o       = oe_n_r;
    assign pair_latched_o    = pair_r;
    assign convert_a_o       = conv_a_r;
    assign convert_b_o       = conv_b_r;
    assign result_a_valid_o  = va_r;
    assign result_b_valid_o  = vb_r;
endmodule

// File: dsc_conv_ctrl_assertions.sv
// assertions on the conversion control ports
`timescale 1ns/1ps
module dsc_conv_ctrl_checker #(
    parameter int CONV_CYC = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic conversion_start_n_i,
    input wire logic low_power_mode_i,
    input wire logic chip_select_n_i,
    input wire logic read_n_i,
    input wire logic busy_o,
    input wire logic end_of_conv_a_o,
    input wire logic low_power_state_o,
    input wire logic data_oe_n_o,
    input wire logic pair_latched_o,
    input wire logic convert_a_o,
    input wire logic convert_b_o,
    input wire logic result_b_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // busy length counted, too long to unroll as a repetition
    logic [7:0] busy_cnt_r;
    logic [7:0] busy_cnt_nxt;
    always_comb begin
        busy_cnt_nxt = busy_o ? busy_cnt_r + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk_i) begin
        busy_cnt_r <= rst_i ? 8'h00 : busy_cnt_nxt;
    end
    property p_busy_conv; busy_o == (convert_a_o || convert_b_o); endproperty
    a_busy_conv: assert property (p_busy_conv) else $error("busy without conversion");
    property p_a_first; $rose(busy_o) |-> convert_a_o ##CONV_CYC $rose(convert_b_o); endproperty
    a_a_first: assert property (p_a_first) else $error("b not after a");
    property p_eoc_a; $rose(convert_b_o) |-> end_of_conv_a_o && $past(convert_a_o); endproperty
    a_eoc_a: assert property (p_eoc_a) else $error("a end pulse missing");
    property p_pair_hold; convert_b_o |-> $stable(pair_latched_o); endproperty
    a_pair_hold: assert property (p_pair_hold) else $error("pair moved");
    property p_busy_width; $fell(busy_o) |-> busy_cnt_r == 8'(2 * CONV_CYC); endproperty
    a_busy_width: assert property (p_busy_width) else $error("busy width");
    property p_b_done; $fell(busy_o) |-> result_b_valid_o && $past(convert_b_o); endproperty
    a_b_done: assert property (p_b_done) else $error("b result missing");
    property p_lp; $fell(busy_o) && low_power_mode_i |-> ##[0:1] low_power_state_o; endproperty
    a_lp: assert property (p_lp) else $error("low power state missing");
    property p_hiz; chip_select_n_i || read_n_i |-> ##3 data_oe_n_o; endproperty
    a_hiz: assert property (p_hiz) else $error("bus driven");
    property p_live; (!chip_select_n_i && !read_n_i) [*4] |-> !data_oe_n_o; endproperty
    a_live: assert property (p_live) else $error("bus not driven");
    property p_no_self; conversion_start_n_i [*5] |-> !$rose(busy_o); endproperty
    a_no_self: assert property (p_no_self) else $error("start without host");
endmodule
bind dsc_conv_ctrl dsc_conv_ctrl_checker #(.CONV_CYC(CONV_CYC)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .conversion_start_n_i(conversion_start_n_i),
    .low_power_mode_i(low_power_mode_i), .chip_select_n_i(chip_select_n_i),
    .read_n_i(read_n_i), .busy_o(busy_o), .end_of_conv_a_o(end_of_conv_a_o),
    .low_power_state_o(low_power_state_o), .data_oe_n_o(data_oe_n_o),
    .pair_latched_o(pair_latched_o), .convert_a_o(convert_a_o), .convert_b_o(convert_b_o),
    .result_b_valid_o(result_b_valid_o));

// File: dsc_host_model.sv
// host model driving conversion start and pair select
`timescale 1ns/1ps
module dsc_host_model (
    input  wire logic clk_i,
    output logic      start_n_o,
    output logic      pair_o
);
    initial begin
        start_n_o = 1'b1;
        pair_o    = 1'b0;
    end
    // pair only moves while idle, well ahead of the start edge
    task automatic pulse(input logic pair, input int low_cyc);
        @(negedge clk_i);
        pair_o = pair;
        repeat (3) @(negedge clk_i);
        start_n_o = 1'b0;
        repeat (low_cyc) @(negedge clk_i);
        start_n_o = 1'b1;
    endtask
endmodule

// File: testbench.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module testbench;
    logic clk_i, rst_i, start_n, pair, pd, lp, cs_n, rd_n, rnd;
    logic busy, eoc, lps, oe_n, pl, ca, cb, ra, rb;
    int fails, n_checks, seed, cyc, bw, n_conv, exp_pair, n0;
    int ab_q[$];
    dsc_conv_ctrl #(.ACQ_CYC(2), .CONV_CYC(4), .AUTO_ACQ_CYC(3)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .conversion_start_n_i(start_n),
        .pair_select_i(pair), .power_down_request_i(pd), .low_power_mode_i(lp),
        .chip_select_n_i(cs_n), .read_n_i(rd_n), .busy_o(busy), .end_of_conv_a_o(eoc),
        .low_power_state_o(lps), .data_oe_n_o(oe_n), .pair_latched_o(pl),
        .convert_a_o(ca), .convert_b_o(cb), .result_a_valid_o(ra), .result_b_valid_o(rb));
    dsc_host_model host (.clk_i(clk_i), .start_n_o(start_n), .pair_o(pair));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task run(input logic p, input int low_cyc);
        int k;
        exp_pair = p;
        host.pulse(p, low_cyc);
        k = 0;
        repeat (3) @(negedge clk_i);
        while (busy === 1'b1 && k < 300) begin
            @(negedge clk_i);
            k++;
        end
        // one more edge so the monitor has booked the last result
        @(negedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            test_done;
        end
    end
    // strobes and power-down toggle freely across conversions
    always @(negedge clk_i) if (rnd) {cs_n, rd_n, pd} <= 3'($random(seed));
    always @(negedge clk_i) begin
        if (rst_i) begin
            bw = 0;
            ab_q.delete();
        end else begin
            if (busy === 1'b1) bw++;
            else if (bw > 0) begin
                check(bw, 8);
                bw = 0;
            end
            if (ra === 1'b1) begin
                check(pl, exp_pair);
                ab_q.push_back(1);
            end
            if (rb === 1'b1) begin
                check(pl, exp_pair);
                check(ab_q.size(), 1);
                ab_q.delete();
                n_conv++;
            end
        end
    end
    initial begin
        seed = 19;
        {fails, n_checks, cyc, bw, n_conv, exp_pair} = '0;
        {rst_i, cs_n, rd_n, pd, lp, rnd} = 6'h38;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        rnd = 1'b1;
        for (int i = 0; i < 4; i++) run(i % 2, 2);
        check(n_conv, 4);
        host.pulse(1'b1, 2);
        run(1'b1, 2);
        check(n_conv, 5);
        run(1'b0, 60);
        check(n_conv, 6);
        // stop the random strobes an edge early so no late write lands
        rnd = 1'b0;
        @(negedge clk_i);
        {cs_n, rd_n, pd, lp} = 4'h1;
        run(1'b0, 100);
        check(n_conv >= 10, 1);
        repeat (2) @(negedge clk_i);
        check(lps, 1);
        check(oe_n, 0);
        {lp, rnd} = 2'h1;
        exp_pair = 1;
        host.pulse(1'b1, 2);
        repeat (3) @(negedge clk_i);
        check(busy, 1);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(busy, 0);
        check(oe_n, 1);
        rst_i = 1'b0;
        n0 = n_conv;
        run(1'b1, 2);
        check(n_conv, n0 + 1);
        test_done;
    end
endmodule
